// >>> logic/cvm_top.sv
`include "cvm_consts.svh"
module cvm_top #(
  parameter logic [6:0] DEV_ADDR = 7'h2a,     // Arbitrary value
  parameter logic [7:0] GAIN_TRIM = 8'h80,    // Arbitrary value
  parameter logic [7:0] OFFSET_TRIM = 8'h80,  // Arbitrary value
  parameter logic [7:0] DET_N = 8'h04,
  parameter logic [7:0] REL_N = 8'h04,
  parameter logic [7:0] TEST_N = 8'h01,
  parameter logic [7:0] SC_DET_N = 8'h02,
  parameter int MON_CYC = `CVM_T_DET_MS * `CVM_CYC_PER_MS,
  parameter int STAB_CYC = `CVM_T_STAB_MS * `CVM_CYC_PER_MS,
  parameter int DROP_CYC = `CVM_T_DROP_MS * `CVM_CYC_PER_MS
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic WAKE_IN_N,
  input wire logic REG_OK,
  input wire cvm_pkg::cvm_cmp_t CMP,
  output logic INT_OUT_N,
  output logic INT_OE,
  output logic ERR_OUT_N,
  output logic ERR_OE,
  output logic SECOND_OV_OUT_N,
  output logic SECOND_OV_OE,
  output logic SHORT_FLAG_OUT_N,
  output logic SHORT_FLAG_OE,
  output logic POWER_DOWN
);
  import cvm_pkg::*;
  cvm_top_st_t st_ff, nxt;
  logic scl_rise, scl_fall, start_c, stop_c, init, mon_tick, oc_run, rd_load, rd_clr, lclr;
  logic ov_act, uv_act, zv_act, sov_act, sc_act;
  logic ov_ent, uv_ent, zv_ent, sov_ent, sc_ent;
  logic [4:0] err, ent;
  logic [7:0] pwr_rd;

  // Register read decode, used on every byte loaded for the host
  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] pw,
                                          input logic [4:0] rq, input logic [4:0] er,
                                          input logic [7:0] ts);
    logic [7:0] d;
    d = 8'h00;
    if (a == `CVM_ADR_POWER) begin
      d = pw;
    end else if (a == `CVM_ADR_IRQ) begin
      d = {3'h0, rq};
    end else if (a == `CVM_ADR_ERR) begin
      d = {3'h0, er};
    end else if (a == `CVM_ADR_GAIN) begin
      d = GAIN_TRIM;
    end else if (a == `CVM_ADR_OFFSET) begin
      d = OFFSET_TRIM;
    end else if (a == `CVM_ADR_TEST) begin
      d = ts;
    end
    return d;
  endfunction

  // Bus edges seen through the synchronisers
  assign scl_rise = st_ff.scl_q & ~st_ff.scl_p;
  assign scl_fall = ~st_ff.scl_q & st_ff.scl_p;
  assign start_c = st_ff.scl_q & st_ff.scl_p & st_ff.sda_p & ~st_ff.sda_q;
  assign stop_c = st_ff.scl_q & st_ff.scl_p & ~st_ff.sda_p & st_ff.sda_q;
  assign rd_load = scl_fall && ((st_ff.ist == I_AACK && st_ff.sh[0]) || st_ff.ist == I_MACK);
  assign rd_clr = rd_load && (st_ff.ptr == `CVM_ADR_IRQ);

  // Initialisation while regulator is low or powered down; timers
  assign init = ~st_ff.reg_q | st_ff.pd;
  assign mon_tick = ~init && (st_ff.mon_cnt == 32'h0);
  assign oc_run = ~init && (st_ff.stab_cnt == 32'h0);
  assign lclr = st_ff.test[`CVM_TST_LCLR];

  // Flag vectors
  assign err[`CVM_BIT_OV] = ov_act;
  assign err[`CVM_BIT_UV] = uv_act;
  assign err[`CVM_BIT_ZV] = zv_act;
  assign err[`CVM_BIT_SOV] = sov_act;
  assign err[`CVM_BIT_SC] = sc_act;
  assign ent[`CVM_BIT_OV] = ov_ent;
  assign ent[`CVM_BIT_UV] = uv_ent;
  assign ent[`CVM_BIT_ZV] = zv_ent;
  assign ent[`CVM_BIT_SOV] = sov_ent;
  assign ent[`CVM_BIT_SC] = sc_ent;
  always_comb begin
    pwr_rd = 8'h00;
    pwr_rd[`CVM_PWR_PD] = st_ff.pd | st_ff.pd_pend;
    pwr_rd[`CVM_PWR_WAKE] = st_ff.wake_q;
  end

  // Next state of synchronisers, serial slave, power control and timers
  always_comb begin
    nxt = st_ff;
    nxt.scl_m = SCL;
    nxt.scl_q = st_ff.scl_m;
    nxt.scl_p = st_ff.scl_q;
    nxt.sda_m = SDA_IN;
    nxt.sda_q = st_ff.sda_m;
    nxt.sda_p = st_ff.sda_q;
    nxt.wake_m = WAKE_IN_N;
    nxt.wake_q = st_ff.wake_m;
    nxt.reg_m = REG_OK;
    nxt.reg_q = st_ff.reg_m;
    nxt.cmp_m = CMP;
    nxt.cmp_q = st_ff.cmp_m;
    nxt.clr_sov = 1'b0;
    nxt.test[`CVM_TST_LCLR] = 1'b0;
    if (start_c) begin
      nxt.ist = I_ADDR;
      nxt.bitc = 4'h0;
      nxt.sda_oe = 1'b0;
    end else if (stop_c) begin
      nxt.ist = I_IDLE;
      nxt.sda_oe = 1'b0;
    end else begin
      case (st_ff.ist)
        I_ADDR, I_REG, I_WDAT: begin
          if (scl_rise) begin
            nxt.sh = {st_ff.sh[6:0], st_ff.sda_q};
            nxt.bitc = st_ff.bitc + 4'h1;
          end else if (scl_fall && st_ff.bitc == 4'h8) begin
            nxt.bitc = 4'h0;
            nxt.sda_oe = 1'b1;
            nxt.ist = I_RACK;
            if (st_ff.ist == I_ADDR) begin
              nxt.ist = (st_ff.sh[7:1] == DEV_ADDR) ? I_AACK : I_IDLE;
              nxt.sda_oe = (st_ff.sh[7:1] == DEV_ADDR);
            end else if (st_ff.ist == I_REG) begin
              nxt.ptr = st_ff.sh;
            end else if (st_ff.ptr == `CVM_ADR_TEST) begin
              nxt.test = st_ff.sh;
            end else if (st_ff.ptr == `CVM_ADR_POWER) begin
              // Request waits while the wake pin is held low
              nxt.pd = st_ff.pd | (st_ff.sh[`CVM_PWR_PD] & st_ff.wake_q);
              nxt.pd_pend = st_ff.sh[`CVM_PWR_PD] & ~st_ff.wake_q;
            end
          end
        end
        I_AACK: begin
          if (scl_fall) begin
            nxt.ist = st_ff.sh[0] ? I_RDAT : I_REG;
            nxt.sh = reg_read(st_ff.ptr, pwr_rd, st_ff.irq, err, st_ff.test);
            nxt.sda_oe = st_ff.sh[0] & ~nxt.sh[7];
            nxt.bitc = 4'h0;
          end
        end
        I_RACK: begin
          if (scl_fall) begin
            nxt.sda_oe = 1'b0;
            nxt.ist = I_WDAT;
          end
        end
        I_RDAT: begin
          if (scl_fall) begin
            nxt.bitc = st_ff.bitc + 4'h1;
            nxt.sh = {st_ff.sh[6:0], 1'b0};
            nxt.sda_oe = ~st_ff.sh[6] && (st_ff.bitc != 4'h7);
            if (st_ff.bitc == 4'h7) begin
              nxt.ist = I_MACK;
            end
          end
        end
        I_MACK: begin
          if (scl_rise && st_ff.sda_q) begin
            nxt.ist = I_IDLE;
          end else if (scl_fall) begin
            nxt.sh = reg_read(st_ff.ptr, pwr_rd, st_ff.irq, err, st_ff.test);
            nxt.sda_oe = ~nxt.sh[7];
            nxt.bitc = 4'h0;
            nxt.ist = I_RDAT;
          end
        end
        default: begin
          nxt.ist = I_IDLE;
        end
      endcase
    end
    // Deferred power-down and wake exit
    if (st_ff.pd_pend && st_ff.wake_q) begin
      nxt.pd = 1'b1;
      nxt.pd_pend = 1'b0;
    end
    if (st_ff.pd && !st_ff.wake_q) begin
      nxt.pd = 1'b0;
      nxt.clr_sov = 1'b1;
    end
    // Long regulator drop also clears the latched state
    if (st_ff.reg_q) begin
      nxt.drop_cnt = 32'h0;
    end else if (st_ff.drop_cnt != 32'(DROP_CYC)) begin
      nxt.drop_cnt = st_ff.drop_cnt + 32'h1;
      nxt.clr_sov = nxt.clr_sov | (st_ff.drop_cnt == 32'(DROP_CYC - 1));
    end
    // Sample interval and overcurrent stabilisation wait
    if (init) begin
      nxt.mon_cnt = 32'h0;
      nxt.stab_cnt = 32'(STAB_CYC);
    end else begin
      nxt.mon_cnt = (st_ff.mon_cnt == 32'h0) ? 32'(MON_CYC - 1) : st_ff.mon_cnt - 32'h1;
      nxt.stab_cnt = (st_ff.stab_cnt == 32'h0) ? 32'h0 : st_ff.stab_cnt - 32'h1;
    end
    // Requests: read clears, new entry wins over the clear
    if (rd_clr || init) begin
      nxt.irq = `CVM_IRQ_RST;
    end
    nxt.irq = nxt.irq | ent;
  end

  // State register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_ff <= '{scl_m: 1'b1, scl_q: 1'b1, scl_p: 1'b1, sda_m: 1'b1, sda_q: 1'b1, sda_p: 1'b1,
                 wake_m: 1'b1, wake_q: 1'b1, reg_m: 1'b0, reg_q: 1'b0, ist: I_IDLE,
                 test: `CVM_TEST_RST, irq: `CVM_IRQ_RST, default: '0};
    end else begin
      st_ff <= nxt;
    end
  end

  // Detect/release filters per condition
  cvm_filter #(.INIT_VAL(1'b0), .LATCH(1'b0), .DET_N(DET_N), .REL_N(REL_N), .TEST_N(TEST_N)) u_ov (
    .clk(CLK), .reset_n(RESET_N), .hold(init), .tick(mon_tick), .det_cond(st_ff.cmp_q.ov_above),
    .rel_cond(st_ff.cmp_q.ov_below_rel), .fast_det(st_ff.test[`CVM_TST_OVD]),
    .fast_rel(st_ff.test[`CVM_TST_RECOVERY_DELAY_SEL]), .active(ov_act), .entry(ov_ent));
  // Undervoltage starts active after any initialisation
  cvm_filter #(.INIT_VAL(1'b1), .LATCH(1'b0), .DET_N(DET_N), .REL_N(REL_N), .TEST_N(TEST_N)) u_uv (
    .clk(CLK), .reset_n(RESET_N), .hold(init), .tick(mon_tick), .det_cond(st_ff.cmp_q.uv_below),
    .rel_cond(st_ff.cmp_q.uv_above_rel), .fast_det(st_ff.test[`CVM_TST_UVD]),
    .fast_rel(st_ff.test[`CVM_TST_RECOVERY_DELAY_SEL]), .active(uv_act), .entry(uv_ent));
  cvm_filter #(.INIT_VAL(1'b0), .LATCH(1'b0), .DET_N(DET_N), .REL_N(REL_N), .TEST_N(TEST_N)) u_zv (
    .clk(CLK), .reset_n(RESET_N), .hold(init), .tick(mon_tick), .det_cond(st_ff.cmp_q.zv_below),
    .rel_cond(~st_ff.cmp_q.zv_below), .fast_det(st_ff.test[`CVM_TST_ZVD]),
    .fast_rel(st_ff.test[`CVM_TST_RECOVERY_DELAY_SEL]), .active(zv_act), .entry(zv_ent));
  // Second overvoltage survives short drops; only the three clears reach it
  cvm_filter #(.INIT_VAL(1'b0), .LATCH(1'b1), .DET_N(DET_N), .REL_N(REL_N), .TEST_N(TEST_N)) u_sov (
    .clk(CLK), .reset_n(RESET_N), .hold(st_ff.clr_sov | lclr), .tick(mon_tick),
    .det_cond(st_ff.cmp_q.sov_above), .rel_cond(1'b0), .fast_det(st_ff.test[`CVM_TST_SECOND_OV_DELAY_SEL]),
    .fast_rel(1'b0), .active(sov_act), .entry(sov_ent));
  cvm_filter #(.INIT_VAL(1'b0), .LATCH(1'b0), .DET_N(SC_DET_N), .REL_N(SC_DET_N), .TEST_N(SC_DET_N)) u_sc (
    .clk(CLK), .reset_n(RESET_N), .hold(~oc_run), .tick(oc_run), .det_cond(st_ff.cmp_q.sc_above),
    .rel_cond(~st_ff.cmp_q.sc_above), .fast_det(1'b0), .fast_rel(1'b0),
    .active(sc_act), .entry(sc_ent));

  // Open-drain pins: value low, enable while asserted
  assign SDA_OUT = 1'b0;
  assign SDA_OE = st_ff.sda_oe;
  assign INT_OUT_N = 1'b0;
  assign INT_OE = |st_ff.irq;
  assign ERR_OUT_N = 1'b0;
  assign ERR_OE = |err;
  assign SECOND_OV_OUT_N = 1'b0;
  assign SECOND_OV_OE = sov_act;
  assign SHORT_FLAG_OUT_N = 1'b0;
  assign SHORT_FLAG_OE = sc_act;
  assign POWER_DOWN = st_ff.pd;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  property p_sov_pin;
    sov_ent |-> SECOND_OV_OE && ERR_OE ##1 st_ff.irq[`CVM_BIT_SOV] && INT_OE;
  endproperty
  a_sov_pin: assert property (p_sov_pin) else $error("second overvoltage pins not asserted");
  property p_sc_pin;
    sc_ent |=> SHORT_FLAG_OE && st_ff.irq[`CVM_BIT_SC];
  endproperty
  a_sc_pin: assert property (p_sc_pin) else $error("short flag pin not asserted");
  property p_lclr_self;
    lclr |=> !lclr;
  endproperty
  a_lclr_self: assert property (p_lclr_self) else $error("latch clear bit did not return to 0");
  property p_lclr_sov;
    lclr |=> !SECOND_OV_OE && !err[`CVM_BIT_SOV];
  endproperty
  a_lclr_sov: assert property (p_lclr_sov) else $error("latch clear left second overvoltage set");
  property p_mon_period;
    mon_tick |=> st_ff.mon_cnt == 32'(MON_CYC - 1);
  endproperty
  a_mon_period: assert property (p_mon_period) else $error("sample interval not reloaded");
  property p_init_uv;
    !st_ff.reg_q |=> err[`CVM_BIT_UV] && ERR_OE && !INT_OE;
  endproperty
  a_init_uv: assert property (p_init_uv) else $error("initial undervoltage state missing");
  property p_ov_irq;
    ov_ent |=> st_ff.irq[`CVM_BIT_OV] && INT_OE && ERR_OE;
  endproperty
  a_ov_irq: assert property (p_ov_irq) else $error("overvoltage entry did not raise request");
  property p_quiet_release;
    (st_ff.irq == 5'h00) && (ent == 5'h00) |=> st_ff.irq == 5'h00;
  endproperty
  a_quiet_release: assert property (p_quiet_release) else $error("request raised without entry");
  property p_rd_clear;
    rd_clr && (ent == 5'h00) |=> (st_ff.irq == 5'h00) && !INT_OE;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("request read did not clear");
  property p_pd_defer;
    $rose(st_ff.pd) |-> $past(st_ff.wake_q);
  endproperty
  a_pd_defer: assert property (p_pd_defer) else $error("power-down entered with wake low");
  property p_oc_wait;
    $fell(init) |-> !oc_run ##1 !oc_run;
  endproperty
  a_oc_wait: assert property (p_oc_wait) else $error("overcurrent watch started without wait");
  // Power-down exit, latch clears, stabilisation wait and initial clearing
  property p_pd_exit;
    st_ff.pd && !st_ff.wake_q |=> !st_ff.pd;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power-down kept with wake low");
  property p_pd_stay;
    st_ff.pd && st_ff.wake_q |=> st_ff.pd;
  endproperty
  a_pd_stay: assert property (p_pd_stay) else $error("power-down left without wake");
  property p_drop_clear;
    !st_ff.reg_q && (st_ff.drop_cnt == 32'(DROP_CYC - 1)) |=> st_ff.clr_sov;
  endproperty
  a_drop_clear: assert property (p_drop_clear) else $error("long regulator drop did not clear");
  property p_clr_sov;
    st_ff.clr_sov |=> !SECOND_OV_OE;
  endproperty
  a_clr_sov: assert property (p_clr_sov) else $error("second overvoltage kept after clear");
  property p_sc_wait;
    !oc_run |=> !SHORT_FLAG_OE;
  endproperty
  a_sc_wait: assert property (p_sc_wait) else $error("short flag outside overcurrent watch");
  property p_init_clear;
    init |=> !ov_act && !zv_act && !sc_act;
  endproperty
  a_init_clear: assert property (p_init_clear) else $error("state not cleared by initialisation");
  c_ov_entry: cover property (ov_ent);
  c_sov_cleared: cover property (SECOND_OV_OE ##1 lclr ##1 !SECOND_OV_OE);
  c_wake_exit: cover property ($fell(st_ff.pd));
  c_read_clear: cover property (rd_clr && INT_OE);
  c_drop_clear: cover property (st_ff.clr_sov && SECOND_OV_OE);
endmodule

// >>> shared/cvm_consts.svh
`ifndef CVM_CONSTS_SVH
`define CVM_CONSTS_SVH
// Behaviour
// - Second-overvoltage output pulled low and its flag reads 1 while detected.
// - Short-circuit output pulled low and its flag reads 1 while detected.
// - Gain calibration readable at 07H; host scales converted monitor output by it.
// - Offset calibration readable at 08H; host adds it in the same equation.
// - Test register at 09H holds per-condition and recovery delay selects.
// - Writing 1 to latch clear drops second-overvoltage flag and releases its pin.
// - Latch clear bit returns to 0 by itself one cycle later.
// - Monitoring starts on regulator recovery and repeats every 0.4 s.
// - After initialization undervoltage flag is set and error pin is low.
// - Overvoltage held for its delay sets request and error flags, pulls pins low.
// - Overvoltage release after delay clears its error only, with no interrupt.
// - Undervoltage held for its delay sets request and error flags, pulls pins low.
// - Undervoltage release after delay clears its error, no interrupt raised.
// - Undervoltage never causes power-down; only the host power-down bit does.
// - Second overvoltage held for its delay drives its pin, error, interrupt and flags.
// - Second overvoltage stays latched until clear bit, power-down plus wake, or 100 ms drop.
// - Below 0-V threshold for its delay sets inhibit request, error, pulls pins low.
// - Above 0-V threshold for enable delay clears inhibit error silently; undervoltage stays.
// - Reading the interrupt request register clears all requests and releases the pin.
// - Overcurrent watch starts 6 ms after recovery; stops in power-down and drop.
// - Power-down is left only when the wake pin is driven low.
// - Error pin is low while any error bit is 1; bits other than second overvoltage clear on resolution.
// - Power-down requested while wake is low waits until wake returns high.
`define CVM_ADR_POWER 8'h04
`define CVM_ADR_IRQ 8'h05
`define CVM_ADR_ERR 8'h06
`define CVM_ADR_GAIN 8'h07
`define CVM_ADR_OFFSET 8'h08
`define CVM_ADR_TEST 8'h09
`define CVM_BIT_OV 0
`define CVM_BIT_UV 1
`define CVM_BIT_ZV 2
`define CVM_BIT_SOV 3
`define CVM_BIT_SC 4
`define CVM_TST_OVD 0
`define CVM_TST_UVD 1
`define CVM_TST_ZVD 2
`define CVM_TST_SECOND_OV_DELAY_SEL 3
`define CVM_TST_RECOVERY_DELAY_SEL 4
`define CVM_TST_LCLR 5
`define CVM_PWR_PD 0
`define CVM_PWR_WAKE 1
`define CVM_TEST_RST 8'h00
`define CVM_IRQ_RST 5'h00
`define CVM_CLK_MHZ 100
`define CVM_CYC_PER_MS (`CVM_CLK_MHZ * 1000)
`define CVM_T_DET_MS 400
`define CVM_T_STAB_MS 6
`define CVM_T_DROP_MS 100
`endif

// >>> shared/cvm_pkg.sv
package cvm_pkg;
  // Comparator outputs from the analog front end
  typedef struct packed {
    logic sov_above;
    logic ov_above;
    logic ov_below_rel;
    logic uv_below;
    logic uv_above_rel;
    logic zv_below;
    logic sc_above;
  } cvm_cmp_t;
  // Serial slave states
  typedef enum logic [7:0] {
    I_IDLE = 8'h01, I_ADDR = 8'h02, I_AACK = 8'h04, I_REG = 8'h08,
    I_RACK = 8'h10, I_WDAT = 8'h20, I_RDAT = 8'h40, I_MACK = 8'h80
  } cvm_i2c_st_t;
  // Detect/release filter state
  typedef struct packed {
    logic act;
    logic [7:0] cnt;
    logic entry;
  } cvm_flt_t;
  // Whole state of the top module
  typedef struct packed {
    logic scl_m, scl_q, scl_p, sda_m, sda_q, sda_p, wake_m, wake_q, reg_m, reg_q;
    cvm_cmp_t cmp_m;
    cvm_cmp_t cmp_q;
    cvm_i2c_st_t ist;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic sda_oe;
    logic pd;
    logic pd_pend;
    logic clr_sov;
    logic [7:0] test;
    logic [4:0] irq;
    logic [31:0] mon_cnt;
    logic [31:0] stab_cnt;
    logic [31:0] drop_cnt;
  } cvm_top_st_t;
endpackage

// >>> logic/cvm_filter.sv
`include "cvm_consts.svh"
module cvm_filter #(
  parameter logic INIT_VAL = 1'b0,
  parameter logic LATCH = 1'b0,
  parameter logic [7:0] DET_N = 8'h04,
  parameter logic [7:0] REL_N = 8'h04,
  parameter logic [7:0] TEST_N = 8'h01
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hold,
  input wire logic tick,
  input wire logic det_cond,
  input wire logic rel_cond,
  input wire logic fast_det,
  input wire logic fast_rel,
  output logic active,
  output logic entry
);
  import cvm_pkg::*;
  cvm_flt_t st_ff, nxt_st;
  logic [7:0] det_lim, rel_lim;

  // Short test delays replace the normal ones when selected
  assign det_lim = fast_det ? TEST_N : DET_N;
  assign rel_lim = fast_rel ? TEST_N : REL_N;
  assign active = st_ff.act;
  assign entry = st_ff.entry;

  // Condition must hold on consecutive samples for the whole delay
  always_comb begin
    nxt_st = st_ff;
    nxt_st.entry = 1'b0;
    if (hold) begin
      nxt_st.act = INIT_VAL;
      nxt_st.cnt = 8'h00;
    end else if (tick) begin
      if (!st_ff.act) begin
        if (det_cond && (st_ff.cnt + 8'h01 >= det_lim)) begin
          nxt_st.act = 1'b1;
          nxt_st.entry = 1'b1;
          nxt_st.cnt = 8'h00;
        end else begin
          nxt_st.cnt = det_cond ? st_ff.cnt + 8'h01 : 8'h00;
        end
      end else if (!LATCH) begin
        if (rel_cond && (st_ff.cnt + 8'h01 >= rel_lim)) begin
          nxt_st.act = 1'b0;
          nxt_st.cnt = 8'h00;
        end else begin
          nxt_st.cnt = rel_cond ? st_ff.cnt + 8'h01 : 8'h00;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '{act: INIT_VAL, cnt: 8'h00, entry: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking fcb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_entry_cause;
    st_ff.entry |-> st_ff.act && $past(det_cond) && $past(tick);
  endproperty
  a_entry_cause: assert property (p_entry_cause) else $error("entry without a detected sample");
  property p_latch_hold;
    LATCH && st_ff.act && !hold |=> st_ff.act;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched state dropped by itself");
endmodule

// >>> testbench/cvm_host_mdl.sv
module cvm_host_mdl (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] dev;
  int nacks;
  // Bus idles released with the clock high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    dev = 7'h2a;
    nacks = 0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data falls while the clock is high, then the clock drops
  task automatic start();
    sda_low <= 1'b0;
    scl <= 1'b1;
    hold(5);
    sda_low <= 1'b1;
    hold(5);
    scl <= 1'b0;
    hold(5);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    hold(5);
    scl <= 1'b1;
    hold(5);
    sda_low <= 1'b0;
    hold(5);
  endtask
  // One bit: data set while low, sampled at the end of the high phase
  task automatic bitx(input logic b, output logic s);
    sda_low <= ~b;
    hold(5);
    scl <= 1'b1;
    hold(5);
    s = sda;
    scl <= 1'b0;
    hold(2);
  endtask
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(last, a);
    if (d != 8'hff && a) begin
      nacks++;
    end
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] q;
    start();
    xfer({dev, 1'b0}, 1'b1, q);
    xfer(ptr, 1'b1, q);
    xfer(d, 1'b1, q);
    stop();
  endtask
  // Host pulls calibration and request registers this way
  task automatic rd(input logic [7:0] ptr, output logic [7:0] q);
    start();
    xfer({dev, 1'b0}, 1'b1, q);
    xfer(ptr, 1'b1, q);
    stop();
    start();
    xfer({dev, 1'b1}, 1'b1, q);
    xfer(8'hff, 1'b1, q);
    stop();
  endtask
endmodule

// >>> testbench/cvm_top_bench.sv
module cvm_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cvm_pkg::*;
  localparam int MON = 20;
  localparam int WT = 7 * MON;
  logic clk, rst_n, wake_n, reg_ok, scl, sda_low;
  logic sda_oe, int_oe, err_oe, sov_oe, sc_oe, pd;
  logic int_n, err_n, sov_n, sc_n, sda_o;
  cvm_cmp_t cmp;
  logic [7:0] q, r;
  int err_count, cmp_count, cyc, exp_err, exp_irq;
  wire sda_w = !(sda_oe || sda_low);
  cvm_top #(.MON_CYC(MON), .STAB_CYC(10), .DROP_CYC(30)) dut_u (.CLK(clk), .RESET_N(rst_n), .SCL(scl),
    .SDA_IN(sda_w), .SDA_OUT(sda_o), .SDA_OE(sda_oe), .WAKE_IN_N(wake_n), .REG_OK(reg_ok), .CMP(cmp),
    .INT_OUT_N(int_n), .INT_OE(int_oe), .ERR_OUT_N(err_n), .ERR_OE(err_oe), .SECOND_OV_OUT_N(sov_n),
    .SECOND_OV_OE(sov_oe), .SHORT_FLAG_OUT_N(sc_n), .SHORT_FLAG_OE(sc_oe), .POWER_DOWN(pd));
  cvm_host_mdl host_u (.clk(clk), .sda(sda_w), .scl(scl), .sda_low(sda_low));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic pins();
    chk("error pin", {7'h00, err_oe}, {7'h00, exp_err != 0});
    chk("irq pin", {7'h00, int_oe}, {7'h00, exp_irq != 0});
    chk("drain levels", {3'h0, sda_o, int_n, err_n, sov_n, sc_n}, 8'h00);
  endtask
  task automatic errs();
    host_u.rd(8'h06, q);
    chk("error reg", q, exp_err[7:0]);
  endtask
  task automatic irqs();
    host_u.rd(8'h05, q);
    chk("irq reg", q, exp_irq[7:0]);
    exp_irq = 0;
    chk("irq pin after read", {7'h00, int_oe}, 8'h00);
  endtask
  task automatic cw(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    rst_n = 1'b0;
    wake_n = 1'b1;
    reg_ok = 1'b1;
    cmp = 7'h14;
    exp_err = 2;
    exp_irq = 0;
    void'($urandom(32'h0774d77b));
    cw(3);
    rst_n <= 1'b1;
    cw(1);
    pins();
    $display("reset done");
    cw(WT);
    exp_err = 0;
    pins();
    // Calibration, test and unmapped registers
    host_u.rd(8'h07, q);
    chk("gain", q, 8'h80);
    r = 8'($urandom);
    host_u.wr(8'h08, r);
    host_u.rd(8'h08, q);
    chk("offset", q, 8'h80);
    host_u.rd(8'h0a, q);
    chk("unmapped", q, 8'h00);
    r = 8'($urandom) & 8'h1f;
    host_u.wr(8'h09, r);
    host_u.rd(8'h09, q);
    chk("test reg", q, r);
    host_u.wr(8'h09, 8'h00);
    host_u.dev = 7'h15;
    host_u.wr(8'h09, 8'h1f);
    host_u.dev = 7'h2a;
    host_u.rd(8'h09, q);
    chk("test reg kept", q, 8'h00);
    chk("nacks", host_u.nacks[7:0], 8'h03);
    $display("registers done");
    // Overvoltage entry and release
    cmp.ov_above <= 1'b1;
    cmp.ov_below_rel <= 1'b0;
    cw(WT);
    exp_err = 1;
    exp_irq = 1;
    pins();
    errs();
    irqs();
    cmp.ov_above <= 1'b0;
    cmp.ov_below_rel <= 1'b1;
    cw(WT);
    exp_err = 0;
    pins();
    $display("overvoltage done");
    // Second overvoltage stays latched until the clear bit
    cmp.sov_above <= 1'b1;
    cw(WT);
    exp_err = 8;
    exp_irq = 8;
    chk("second ov pin", {7'h00, sov_oe}, 8'h01);
    pins();
    cmp.sov_above <= 1'b0;
    cw(WT);
    chk("second ov held", {7'h00, sov_oe}, 8'h01);
    irqs();
    errs();
    host_u.wr(8'h09, 8'h20);
    exp_err = 0;
    chk("second ov cleared", {7'h00, sov_oe}, 8'h00);
    host_u.rd(8'h09, q);
    chk("clear bit", q, 8'h00);
    pins();
    $display("second overvoltage done");
    // Short circuit
    cmp.sc_above <= 1'b1;
    cw(10);
    chk("short pin", {7'h00, sc_oe}, 8'h01);
    exp_err = 16;
    exp_irq = 16;
    errs();
    irqs();
    cmp.sc_above <= 1'b0;
    cw(20);
    exp_err = 0;
    pins();
    $display("short circuit done");
    // Undervoltage with 0-V inhibit
    cmp.uv_below <= 1'b1;
    cmp.uv_above_rel <= 1'b0;
    cmp.zv_below <= 1'b1;
    cw(WT);
    exp_err = 6;
    exp_irq = 6;
    pins();
    errs();
    chk("no power-down", {7'h00, pd}, 8'h00);
    irqs();
    cmp.zv_below <= 1'b0;
    cw(WT);
    exp_err = 2;
    errs();
    pins();
    cmp.uv_below <= 1'b0;
    cmp.uv_above_rel <= 1'b1;
    cw(WT);
    exp_err = 0;
    pins();
    $display("undervoltage done");
    // Power-down deferred while wake is low, left on wake low, clearing the latch
    cmp.sov_above <= 1'b1;
    cw(WT);
    cmp.sov_above <= 1'b0;
    wake_n <= 1'b0;
    cw(5);
    host_u.wr(8'h04, 8'h01);
    chk("pd deferred", {7'h00, pd}, 8'h00);
    host_u.rd(8'h04, q);
    chk("power reg pending", q, 8'h01);
    wake_n <= 1'b1;
    cw(10);
    chk("pd entered", {7'h00, pd}, 8'h01);
    chk("second ov in power-down", {7'h00, sov_oe}, 8'h01);
    wake_n <= 1'b0;
    cw(10);
    chk("pd left", {7'h00, pd}, 8'h00);
    chk("second ov after wake", {7'h00, sov_oe}, 8'h00);
    wake_n <= 1'b1;
    cw(WT);
    pins();
    $display("power-down done");
    // Short regulator drop keeps the latch, a long one clears it
    cmp.sov_above <= 1'b1;
    cw(WT);
    cmp.sov_above <= 1'b0;
    reg_ok <= 1'b0;
    cw(10);
    reg_ok <= 1'b1;
    cw(5);
    chk("second ov after short drop", {7'h00, sov_oe}, 8'h01);
    reg_ok <= 1'b0;
    cw(45);
    chk("second ov after long drop", {7'h00, sov_oe}, 8'h00);
    exp_err = 2;
    exp_irq = 0;
    pins();
    reg_ok <= 1'b1;
    cw(WT);
    exp_err = 0;
    pins();
    $display("regulator drop done");
    test_done();
  end
endmodule
